//--- lps_regs.sv
`timescale 1ns/10ps
// upper register bank of the light/proximity sensor: control, id, status, results
//
// Behaviour
// - drive field scales LED current by halves
// - diode field picks channel 0, 1, both
// - part identifier at 0x12, read only
// - status at 0x13 is read only
// - status bit 5 shows proximity interrupt
// - status bit 4 shows light interrupt
// - status bit 0 set after integration done
// - light results as low/high byte pairs
// - light low read latches high byte
// - proximity low read latches high byte
module lps_regs #(
  parameter logic [7:0] PART_ID = 8'h5A // arbitrary value
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // register port from the serial command engine
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID,
  // measurement engine
  input wire lps_pkg::lps_meas_s MEAS,
  // analog front end settings
  output lps_pkg::lps_ctrl_s CTRL
);
  logic [7:0] ctrl_q;
  logic light_valid_q;
  logic [7:0] status_d;
  logic [7:0] rdata_d;
  logic [lps_pkg::NUM_SHADOW-1:0] capture;
  logic [lps_pkg::NUM_SHADOW-1:0][7:0] live_hi;
  logic [lps_pkg::NUM_SHADOW-1:0][7:0] held_hi;
  logic [1:0] led_field;
  lps_pkg::lps_gain_e gain_code;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_q <= lps_pkg::ANALOG_CONTROL_RESET;
    end else if (REG_WR && REG_ADDR == lps_pkg::ADDR_ANALOG_CONTROL) begin
      // reserved bits kept as written; nothing decodes them
      ctrl_q <= REG_WDATA;
    end
  end

  // sticky valid: a completion in the clearing cycle wins
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      light_valid_q <= 1'b0;
    end else if (MEAS.light_done) begin
      light_valid_q <= 1'b1;
    end else if (MEAS.light_valid_clr) begin
      light_valid_q <= 1'b0;
    end
  end

  assign led_field = ctrl_q[lps_pkg::LED_DRIVE_HI:lps_pkg::LED_DRIVE_LO];
  assign gain_code = lps_pkg::lps_gain_e'(ctrl_q[lps_pkg::GAIN_HI:lps_pkg::GAIN_LO]);

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      CTRL <= '0;
    end else begin
      CTRL.led_current <= lps_pkg::LED_CURRENT_FULL >> led_field;
      // code 00 is reserved: no diode rather than a guess
      CTRL.prox_diode_en <= ctrl_q[lps_pkg::PROX_DIODE_HI:lps_pkg::PROX_DIODE_LO];
      case (gain_code)
        lps_pkg::GAIN_CODE_X1: CTRL.gain_mult <= lps_pkg::GAIN_X1;
        lps_pkg::GAIN_CODE_X8: CTRL.gain_mult <= lps_pkg::GAIN_X8;
        lps_pkg::GAIN_CODE_X16: CTRL.gain_mult <= lps_pkg::GAIN_X16;
        default: CTRL.gain_mult <= lps_pkg::GAIN_RESERVED;
      endcase
    end
  end

  always_comb begin
    status_d = 8'h00;
    status_d[lps_pkg::STAT_PROX_IRQ] = MEAS.prox_irq;
    status_d[lps_pkg::STAT_LIGHT_IRQ] = MEAS.light_irq;
    status_d[lps_pkg::STAT_LIGHT_VALID] = light_valid_q;
  end

  // a low-byte read freezes its upper byte for the following high read
  assign live_hi[lps_pkg::SH_CH0] = MEAS.ch0[15:8];
  assign live_hi[lps_pkg::SH_CH1] = MEAS.ch1[15:8];
  assign live_hi[lps_pkg::SH_PROX] = MEAS.prox[15:8];
  assign capture[lps_pkg::SH_CH0] = REG_RD && REG_ADDR == lps_pkg::ADDR_LIGHT_CH0_LOW;
  assign capture[lps_pkg::SH_CH1] = REG_RD && REG_ADDR == lps_pkg::ADDR_LIGHT_CH1_LOW;
  assign capture[lps_pkg::SH_PROX] = REG_RD && REG_ADDR == lps_pkg::ADDR_PROXIMITY_LOW;

  lps_shadow u_shadow (
    .clk(CLK),
    .resetn(RESETN),
    .capture(capture),
    .live_hi(live_hi),
    .held_hi(held_hi)
  );

  always_comb begin
    if (REG_ADDR == lps_pkg::ADDR_ANALOG_CONTROL) begin
      rdata_d = ctrl_q;
    end else if (REG_ADDR == lps_pkg::ADDR_PART_IDENTIFIER) begin
      rdata_d = PART_ID;
    end else if (REG_ADDR == lps_pkg::ADDR_DEVICE_STATUS) begin
      rdata_d = status_d;
    end else if (REG_ADDR == lps_pkg::ADDR_LIGHT_CH0_LOW) begin
      rdata_d = MEAS.ch0[7:0];
    end else if (REG_ADDR == lps_pkg::ADDR_LIGHT_CH0_HIGH) begin
      rdata_d = held_hi[lps_pkg::SH_CH0];
    end else if (REG_ADDR == lps_pkg::ADDR_LIGHT_CH1_LOW) begin
      rdata_d = MEAS.ch1[7:0];
    end else if (REG_ADDR == lps_pkg::ADDR_LIGHT_CH1_HIGH) begin
      rdata_d = held_hi[lps_pkg::SH_CH1];
    end else if (REG_ADDR == lps_pkg::ADDR_PROXIMITY_LOW) begin
      rdata_d = MEAS.prox[7:0];
    end else if (REG_ADDR == lps_pkg::ADDR_PROXIMITY_HIGH) begin
      rdata_d = held_hi[lps_pkg::SH_PROX];
    end else begin
      rdata_d = lps_pkg::RDATA_UNMAPPED;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      REG_RDATA <= 8'h00;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
      if (REG_RD) begin
        REG_RDATA <= rdata_d;
      end
    end
  end

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  property p_led_scale;
    (REG_WR && REG_ADDR == lps_pkg::ADDR_ANALOG_CONTROL)
      |-> ##2 (CTRL.led_current == (lps_pkg::LED_CURRENT_FULL
        >> $past(REG_WDATA[lps_pkg::LED_DRIVE_HI:lps_pkg::LED_DRIVE_LO], 2)));
  endproperty
  a_led_scale: assert property (p_led_scale) else $error("led current not scaled");

  property p_diode_sel;
    (REG_WR && REG_ADDR == lps_pkg::ADDR_ANALOG_CONTROL)
      |-> ##2 (CTRL.prox_diode_en
        == $past(REG_WDATA[lps_pkg::PROX_DIODE_HI:lps_pkg::PROX_DIODE_LO], 2));
  endproperty
  a_diode_sel: assert property (p_diode_sel) else $error("diode select wrong");

  property p_gain;
    (REG_WR && REG_ADDR == lps_pkg::ADDR_ANALOG_CONTROL
      && REG_WDATA[lps_pkg::GAIN_HI:lps_pkg::GAIN_LO] == lps_pkg::GAIN_CODE_X8)
      |-> ##2 (CTRL.gain_mult == lps_pkg::GAIN_X8);
  endproperty
  a_gain: assert property (p_gain) else $error("gain not 8x");

  property p_id_read;
    (REG_RD && REG_ADDR == lps_pkg::ADDR_PART_IDENTIFIER) |=> (REG_RVALID && REG_RDATA == PART_ID);
  endproperty
  a_id_read: assert property (p_id_read) else $error("id read wrong");

  property p_ro_write;
    (REG_WR && REG_ADDR != lps_pkg::ADDR_ANALOG_CONTROL) |=> $stable(ctrl_q);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only write changed state");

  property p_prox_irq;
    (REG_RD && REG_ADDR == lps_pkg::ADDR_DEVICE_STATUS)
      |=> (REG_RDATA[lps_pkg::STAT_PROX_IRQ] == $past(MEAS.prox_irq));
  endproperty
  a_prox_irq: assert property (p_prox_irq) else $error("status prox irq wrong");

  property p_light_irq;
    (REG_RD && REG_ADDR == lps_pkg::ADDR_DEVICE_STATUS)
      |=> (REG_RDATA[lps_pkg::STAT_LIGHT_IRQ] == $past(MEAS.light_irq));
  endproperty
  a_light_irq: assert property (p_light_irq) else $error("status light irq wrong");

  property p_valid_set;
    MEAS.light_done |=> light_valid_q;
  endproperty
  a_valid_set: assert property (p_valid_set) else $error("valid not set");

  property p_ch0_coherent;
    (REG_RD && REG_ADDR == lps_pkg::ADDR_LIGHT_CH0_LOW)
      ##1 (REG_RD && REG_ADDR == lps_pkg::ADDR_LIGHT_CH0_HIGH)
      |=> (REG_RDATA == $past(MEAS.ch0[15:8], 2));
  endproperty
  a_ch0_coherent: assert property (p_ch0_coherent) else $error("ch0 high not latched");

  property p_prox_coherent;
    (REG_RD && REG_ADDR == lps_pkg::ADDR_PROXIMITY_LOW)
      ##1 (REG_RD && REG_ADDR == lps_pkg::ADDR_PROXIMITY_HIGH)
      |=> (REG_RDATA == $past(MEAS.prox[15:8], 2));
  endproperty
  a_prox_coherent: assert property (p_prox_coherent) else $error("prox high not latched");

  property p_cov_pair;
    (REG_RD && REG_ADDR == lps_pkg::ADDR_LIGHT_CH1_LOW) ##1
      (REG_RD && REG_ADDR == lps_pkg::ADDR_LIGHT_CH1_HIGH);
  endproperty
  c_cov_pair: cover property (p_cov_pair);

  property p_cov_ctrl;
    REG_WR && REG_ADDR == lps_pkg::ADDR_ANALOG_CONTROL;
  endproperty
  c_cov_ctrl: cover property (p_cov_ctrl);

  property p_cov_valid_race;
    MEAS.light_done && MEAS.light_valid_clr;
  endproperty
  c_cov_valid_race: cover property (p_cov_valid_race);
endmodule // lps_regs

//--- lps_pkg.sv
// constants, register map and carrier types for the light/proximity register bank
package lps_pkg;
  localparam logic [7:0] ADDR_ANALOG_CONTROL = 8'h0F;
  localparam logic [7:0] ADDR_PART_IDENTIFIER = 8'h12;
  localparam logic [7:0] ADDR_DEVICE_STATUS = 8'h13;
  localparam logic [7:0] ADDR_LIGHT_CH0_LOW = 8'h14;
  localparam logic [7:0] ADDR_LIGHT_CH0_HIGH = 8'h15;
  localparam logic [7:0] ADDR_LIGHT_CH1_LOW = 8'h16;
  localparam logic [7:0] ADDR_LIGHT_CH1_HIGH = 8'h17;
  localparam logic [7:0] ADDR_PROXIMITY_LOW = 8'h18;
  localparam logic [7:0] ADDR_PROXIMITY_HIGH = 8'h19;

  // analog control field positions
  localparam int LED_DRIVE_HI = 7;
  localparam int LED_DRIVE_LO = 6;
  localparam int PROX_DIODE_HI = 5;
  localparam int PROX_DIODE_LO = 4;
  localparam int GAIN_HI = 1;
  localparam int GAIN_LO = 0;

  // device status bit positions
  localparam int STAT_PROX_IRQ = 5;
  localparam int STAT_LIGHT_IRQ = 4;
  localparam int STAT_LIGHT_VALID = 0;

  localparam logic [7:0] ANALOG_CONTROL_RESET = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
  // full trimmed current as a fraction of 128; each drive step halves it
  localparam logic [7:0] LED_CURRENT_FULL = 8'h80;

  // gain multipliers; the top code is reserved and treated as no gain
  localparam logic [4:0] GAIN_X1 = 5'h01;
  localparam logic [4:0] GAIN_X8 = 5'h08;
  localparam logic [4:0] GAIN_X16 = 5'h10;
  localparam logic [4:0] GAIN_RESERVED = 5'h00;

  localparam int NUM_SHADOW = 3;
  localparam int SH_CH0 = 0;
  localparam int SH_CH1 = 1;
  localparam int SH_PROX = 2;

  typedef enum logic [1:0] {
    GAIN_CODE_X1 = 2'b00,
    GAIN_CODE_X8 = 2'b01,
    GAIN_CODE_X16 = 2'b10,
    GAIN_CODE_RSVD = 2'b11
  } lps_gain_e;

  // results and events from the measurement engine, same clock
  typedef struct packed {
    logic [15:0] ch0;
    logic [15:0] ch1;
    logic [15:0] prox;
    logic light_done;
    logic light_valid_clr;
    logic prox_irq;
    logic light_irq;
  } lps_meas_s;

  // settings steering the analog front end
  typedef struct packed {
    logic [7:0] led_current;
    logic [1:0] prox_diode_en;
    logic [4:0] gain_mult;
  } lps_ctrl_s;
endpackage

//--- lps_shadow.sv
`timescale 1ns/10ps
// per-result shadow latches for the upper bytes
module lps_shadow (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // capture strobes and live upper bytes
  input wire logic [lps_pkg::NUM_SHADOW-1:0] capture,
  input wire logic [lps_pkg::NUM_SHADOW-1:0][7:0] live_hi,
  // held upper bytes
  output logic [lps_pkg::NUM_SHADOW-1:0][7:0] held_hi
);
  genvar i;
  generate
    for (i = 0; i < lps_pkg::NUM_SHADOW; i++) begin : g_sh
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          held_hi[i] <= 8'h00;
        end else if (capture[i]) begin
          held_hi[i] <= live_hi[i];
        end
      end
    end
  endgenerate
endmodule // lps_shadow

//--- lps_meas_model.sv
`timescale 1ns/10ps
// behavioural measurement engine feeding results and events to the bank
module lps_meas_model (
  // clock
  input wire logic clk,
  // results and events toward the bank
  output lps_pkg::lps_meas_s meas
);
  initial begin
    meas = '0;
  end

  // results hold until replaced, like a finished conversion
  task automatic set_res(input int idx, input logic [15:0] val);
    @(posedge clk);
    case (idx)
      0: meas.ch0 <= val;
      1: meas.ch1 <= val;
      default: meas.prox <= val;
    endcase
  endtask

  task automatic set_irq(input logic p, input logic l);
    @(posedge clk);
    meas.prox_irq <= p;
    meas.light_irq <= l;
  endtask

  // one-cycle event pulses
  task automatic pulse(input logic d, input logic c);
    @(posedge clk);
    meas.light_done <= d;
    meas.light_valid_clr <= c;
    @(posedge clk);
    meas.light_done <= 1'b0;
    meas.light_valid_clr <= 1'b0;
  endtask
endmodule // lps_meas_model

//--- tb_top.sv
`timescale 1ns/10ps
// self-checking bench for the upper register bank
module tb_top;
  localparam logic [7:0] ID_VAL = 8'hC3; // arbitrary value
  logic CLK, RESETN, REG_WR, REG_RD, REG_RVALID;
  logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
  lps_pkg::lps_meas_s MEAS;
  lps_pkg::lps_ctrl_s CTRL;
  int num_errors = 0;
  int total_checks = 0;
  logic [7:0] gain_tab [4] = '{8'h01, 8'h08, 8'h10, 8'h00};

  lps_regs #(.PART_ID(ID_VAL)) i_dut (.CLK(CLK), .RESETN(RESETN), .REG_ADDR(REG_ADDR),
    .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .REG_RVALID(REG_RVALID), .MEAS(MEAS), .CTRL(CTRL));
  lps_meas_model i_meas (.clk(CLK), .meas(MEAS));

  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask

  // answer is registered on the same edge that takes the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(posedge CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLK);
    REG_RD <= 1'b0;
    #1;
    chk({nm, " rvalid"}, 8'h01, {7'h00, REG_RVALID});
    chk(nm, e, REG_RDATA);
  endtask

  // low then high on consecutive cycles, as an auto-increment burst delivers them
  task automatic rd_pair(input logic [7:0] a, input logic [7:0] e_lo, input logic [7:0] e_hi,
    input string nm);
    @(posedge CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLK);
    REG_ADDR <= a + 8'h01;
    #1;
    chk({nm, " low"}, e_lo, REG_RDATA);
    @(posedge CLK);
    REG_RD <= 1'b0;
    #1;
    chk({nm, " rvalid"}, 8'h01, {7'h00, REG_RVALID});
    chk({nm, " high"}, e_hi, REG_RDATA);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    logic [7:0] v;
    logic [7:0] a;
    logic [15:0] old_v;
    RESETN = 1'b0;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_ADDR = 8'h00;
    REG_WDATA = 8'h00;
    repeat (20) @(posedge CLK);
    RESETN <= 1'b1;
    @(posedge CLK);
    #1;
    chk("led reset", 8'h80, CTRL.led_current);
    chk("gain reset", 8'h01, {3'h0, CTRL.gain_mult});
    rd(lps_pkg::ADDR_ANALOG_CONTROL, lps_pkg::ANALOG_CONTROL_RESET, "control");
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      // reserved bits 3:2 always written as zero
      v = {i[1:0], i[1:0], 2'b00, i[1:0]};
      wr(lps_pkg::ADDR_ANALOG_CONTROL, v);
      repeat (2) @(posedge CLK);
      #1;
      chk("led", 8'h80 >> i, CTRL.led_current);
      chk("diode", {6'h00, i[1:0]}, {6'h00, CTRL.prox_diode_en});
      chk("gain", gain_tab[i], {3'h0, CTRL.gain_mult});
      rd(lps_pkg::ADDR_ANALOG_CONTROL, v, "control");
    end
    $display("test control done");
    wr(lps_pkg::ADDR_PART_IDENTIFIER, 8'h00);
    wr(lps_pkg::ADDR_DEVICE_STATUS, 8'hFF);
    rd(lps_pkg::ADDR_PART_IDENTIFIER, ID_VAL, "part id");
    rd(lps_pkg::ADDR_ANALOG_CONTROL, v, "control kept");
    i_meas.set_irq(1'b1, 1'b0);
    i_meas.pulse(1'b1, 1'b0);
    rd(lps_pkg::ADDR_DEVICE_STATUS, 8'h21, "status prox");
    rd(lps_pkg::ADDR_DEVICE_STATUS, 8'h21, "status sticky");
    i_meas.set_irq(1'b0, 1'b1);
    i_meas.pulse(1'b0, 1'b1);
    rd(lps_pkg::ADDR_DEVICE_STATUS, 8'h10, "status light");
    i_meas.set_irq(1'b0, 1'b0);
    i_meas.pulse(1'b1, 1'b1);
    rd(lps_pkg::ADDR_DEVICE_STATUS, 8'h01, "status set wins");
    $display("test status done");
    for (int c = 0; c < 3; c++) begin
      a = lps_pkg::ADDR_LIGHT_CH0_LOW + 8'(2 * c);
      old_v = 16'h1234 + 16'(16'h1111 * c);
      i_meas.set_res(c, old_v);
      rd(a, old_v[7:0], "result low");
      // a newer conversion lands between the two byte reads
      i_meas.set_res(c, ~old_v);
      rd(a + 8'h01, old_v[15:8], "result high shadow");
      rd(a, ~old_v[7:0], "pair low");
      rd(a + 8'h01, ~old_v[15:8], "pair high");
      // a conversion lands between the two bytes of one burst
      fork
        begin
          @(posedge CLK);
          i_meas.set_res(c, old_v);
        end
        rd_pair(a, ~old_v[7:0], ~old_v[15:8], "burst");
      join
    end
    $display("test results done");
    rd(8'h20, lps_pkg::RDATA_UNMAPPED, "unmapped");
    $display("test unmapped done");
    end_of_test();
  end
endmodule // tb_top
